// ===== hw/red_pkg.sv
// package: register map, timing and carrier types of the energy detector
package red_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STRENGTH = 8'h06;
  localparam logic [7:0] IDX_ENERGY   = 8'h07;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h08;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h09;

  // field positions
  localparam int STR_CRC_BIT = 7;
  localparam int STR_RND_LSB = 5;
  localparam int IRQ_DONE_BIT = 0;

  // reset values
  localparam logic [7:0] RST_STRENGTH = 8'h60;
  localparam logic [7:0] RST_ENERGY   = 8'hff;
  localparam logic [1:0] RST_RANDOM   = 2'h3;
  localparam logic [4:0] RST_STR_VAL  = 5'h00;
  localparam logic       RST_IRQ_MASK = 1'h0;

  // value limits
  localparam logic [4:0] STR_MAX    = 5'h1c;
  localparam logic [7:0] ENERGY_MAX = 8'h53;

  // timing
  localparam int CLK_MHZ        = 125;
  localparam int STR_PERIOD_US  = 2;
  localparam int STR_TICK_CYC   = STR_PERIOD_US * CLK_MHZ;
  localparam int ED_WINDOW_US   = 128;
  localparam int ED_SAMPLES     = ED_WINDOW_US / STR_PERIOD_US;
  localparam int ED_PROC_CYC    = 4;

  // samples arriving from the receiver, all on pclk
  typedef struct packed {
    logic       rx_active;   // listening or busy receiving
    logic       header_det;  // pulse: valid sync header seen
    logic       rx_start;    // pulse: receive-start event
    logic       frame_end;   // pulse: frame_end_irq event
    logic       crc_ok;      // checksum result, valid at frame_end
    logic [1:0] random_bits; // random source
    logic [4:0] power;       // raw strength sample
  } red_rx_t;

  typedef enum logic [1:0] {
    ED_IDLE,
    ED_MEASURE,
    ED_PROCESS
  } red_ed_state_t;

endpackage

// ===== hw/red_rssi_energy_detect.sv
// received-strength readout and energy detection with apb registers
// How it works
// - strength is 5-bit read-only, 0 to 28
// - refresh strength every 2us in receive states
// - one step 3dB, 0 base, 28 at -7dBm
// - energy averages strength over eight symbols
// - a write to energy register in rx, outside a locked frame, starts measurement
// - manual requests in rx only; done raises interrupt
// - header starts measurement, no interrupt at end
// - no second update during the same frame
// - result stored within window plus processing delay
// - frame result stable until next frame or start
// - result 0x00..0x53, 0xff until first measurement
// - result zero at base, else base plus dB
// - request outside rx: interrupt, no measurement
// - strength register: crc, random bits, strength
//
// Local design decision: the APB register port.
module red_rssi_energy_detect (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // receiver side
  input  wire red_pkg::red_rx_t  rx_in,
  // interrupt
  output logic                   measure_done_irq
);

  logic [7:0]                 tick_cnt_ff;
  logic                       tick;
  logic [4:0]                 strength_ff;
  logic [1:0]                 random_ff;
  logic                       crc_ff;
  logic [7:0]                 energy_ff;
  red_pkg::red_ed_state_t     state_ff;
  logic [6:0]                 samp_cnt_ff;
  logic [10:0]                sum_ff;
  logic [2:0]                 proc_cnt_ff;
  logic                       manual_ff;
  logic                       frame_lock_ff;
  logic                       done_ff;
  logic                       mask_ff;
  logic                       pready_ff;
  logic [31:0]                prdata_ff;
  logic                       pslverr_ff;
  logic                       irq_ff;
  logic [4:0]                 power_clamped;
  logic [9:0]                 index;
  logic                       mapped;
  logic                       access;
  logic                       wr_done;
  logic                       manual_req;
  logic                       done_set;
  logic [12:0]                scaled;
  logic [7:0]                 avg_db;
  logic [7:0]                 nxt_energy;
  logic                       nxt_done;
  logic                       start_auto;
  logic                       start_manual;
  logic                       start_any;
  logic                       sampling;
  logic                       last_sample;
  logic                       proc_last;
  logic                       store_cycle;
  logic [31:0]                nxt_prdata;

  assign pready           = pready_ff;
  assign prdata           = prdata_ff;
  assign pslverr          = pslverr_ff;
  assign measure_done_irq = irq_ff;

  // apb decode; byte lanes ignored, all fields fit one byte
  assign index  = paddr[11:2];
  assign mapped = (index == {2'h0, red_pkg::IDX_STRENGTH}) ||
                  (index == {2'h0, red_pkg::IDX_ENERGY})   ||
                  (index == {2'h0, red_pkg::IDX_IRQ_STAT}) ||
                  (index == {2'h0, red_pkg::IDX_IRQ_MASK});
  assign access  = psel && penable && !pready_ff;
  assign wr_done = psel && penable && pready_ff && pwrite && mapped;

  assign manual_req = wr_done &&
                      (index == {2'h0, red_pkg::IDX_ENERGY});

  // 2us sampling tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= 8'h00;
    end else if (tick) begin
      tick_cnt_ff <= 8'h00;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 8'h01;
    end
  end
  assign tick = (tick_cnt_ff == 8'(red_pkg::STR_TICK_CYC - 1));

  assign power_clamped = (rx_in.power > red_pkg::STR_MAX) ?
                         red_pkg::STR_MAX : rx_in.power;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strength_ff <= red_pkg::RST_STR_VAL;
    end else if (tick && rx_in.rx_active) begin
      strength_ff <= power_clamped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      random_ff <= red_pkg::RST_RANDOM;
    end else if (tick && rx_in.rx_active) begin
      random_ff <= rx_in.random_bits;
    end
  end

  // checksum flag held from one frame end to the next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_ff <= 1'b0;
    end else if (rx_in.frame_end) begin
      crc_ff <= rx_in.crc_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_lock_ff <= 1'b0;
    end else if (rx_in.header_det) begin
      frame_lock_ff <= 1'b1;
    end else if (rx_in.frame_end || !rx_in.rx_active) begin
      frame_lock_ff <= 1'b0;
    end
  end

  assign scaled = 13'(sum_ff) * 13'h0003;
  // quotient needs seven bits: 64 samples of 28 give 84
  assign avg_db = {1'b0, scaled[12:6]};

  always_comb begin
    nxt_energy = (avg_db > red_pkg::ENERGY_MAX) ?
                 red_pkg::ENERGY_MAX : avg_db;
  end

  // start requests; a header beats a manual write
  assign start_auto   = rx_in.header_det && rx_in.rx_active;
  assign start_manual = manual_req && rx_in.rx_active && !frame_lock_ff;
  assign start_any    = start_auto || start_manual;
  assign sampling     = (state_ff == red_pkg::ED_MEASURE) &&
                        rx_in.rx_active && tick;
  assign last_sample  = sampling &&
                        (samp_cnt_ff == 7'(red_pkg::ED_SAMPLES - 1));
  assign proc_last    = (state_ff == red_pkg::ED_PROCESS) &&
                        (proc_cnt_ff == 3'(red_pkg::ED_PROC_CYC - 1));
  // full window only; a new start in this cycle wins
  assign store_cycle  = proc_last && !start_any &&
                        (samp_cnt_ff == 7'(red_pkg::ED_SAMPLES));

  // measurement sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= red_pkg::ED_IDLE;
    end else if (start_any) begin
      state_ff <= red_pkg::ED_MEASURE;
    end else begin
      case (state_ff)
        red_pkg::ED_IDLE: begin
          state_ff <= red_pkg::ED_IDLE;
        end
        red_pkg::ED_MEASURE: begin
          // leaving rx abandons the window, result kept
          if (!rx_in.rx_active || last_sample) begin
            state_ff <= red_pkg::ED_PROCESS;
          end
        end
        red_pkg::ED_PROCESS: begin
          if (proc_last) begin
            state_ff <= red_pkg::ED_IDLE;
          end
        end
        default: begin
          state_ff <= red_pkg::ED_IDLE;
        end
      endcase
    end
  end

  // samples taken in the current window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_cnt_ff <= 7'h00;
    end else if (start_any) begin
      samp_cnt_ff <= 7'h00;
    end else if (sampling) begin
      samp_cnt_ff <= samp_cnt_ff + 7'h01;
    end
  end

  // 64 samples of 28 fit 11 bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_ff <= 11'h000;
    end else if (start_any) begin
      sum_ff <= 11'h000;
    end else if (sampling) begin
      sum_ff <= sum_ff + {6'h00, strength_ff};
    end
  end

  // processing delay; an abandoned run skips it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proc_cnt_ff <= 3'h0;
    end else if (state_ff == red_pkg::ED_MEASURE && !rx_in.rx_active) begin
      proc_cnt_ff <= 3'(red_pkg::ED_PROC_CYC - 1);
    end else if (last_sample) begin
      proc_cnt_ff <= 3'h0;
    end else if (state_ff == red_pkg::ED_PROCESS && !proc_last) begin
      proc_cnt_ff <= proc_cnt_ff + 3'h1;
    end
  end

  // manual run remembered for the done flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_ff <= 1'b0;
    end else if (start_auto) begin
      manual_ff <= 1'b0;
    end else if (start_manual) begin
      manual_ff <= 1'b1;
    end else if (state_ff == red_pkg::ED_IDLE) begin
      manual_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      energy_ff <= red_pkg::RST_ENERGY;
    end else if (store_cycle) begin
      energy_ff <= nxt_energy;
    end
  end

  // done even when refused
  // an abandoned manual run still reports done
  assign done_set = (manual_req && !start_manual) ||
                    (manual_ff && proc_last && !start_any);

  // sticky done; a set in the clearing cycle wins
  always_comb begin
    nxt_done = done_ff;
    if (wr_done && index == {2'h0, red_pkg::IDX_IRQ_STAT} &&
        pwdata[red_pkg::IRQ_DONE_BIT]) begin
      nxt_done = 1'b0;
    end
    if (done_set) begin
      nxt_done = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_done && mask_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= red_pkg::RST_IRQ_MASK;
    end else if (wr_done && index == {2'h0, red_pkg::IDX_IRQ_MASK}) begin
      mask_ff <= pwdata[red_pkg::IRQ_DONE_BIT];
    end
  end

  // read mux; zero outside a read access
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (access && !pwrite) begin
      case (index)
        {2'h0, red_pkg::IDX_STRENGTH}: begin
          nxt_prdata[7:0] = {crc_ff, random_ff, strength_ff};
        end
        {2'h0, red_pkg::IDX_ENERGY}: begin
          nxt_prdata[7:0] = energy_ff;
        end
        {2'h0, red_pkg::IDX_IRQ_STAT}: begin
          nxt_prdata[red_pkg::IRQ_DONE_BIT] = done_ff;
        end
        {2'h0, red_pkg::IDX_IRQ_MASK}: begin
          nxt_prdata[red_pkg::IRQ_DONE_BIT] = mask_ff;
        end
        default: begin
          nxt_prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // apb answer: one wait state, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= access;
    end
  end

  // unmapped index refused, write dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= access && !mapped;
    end
  end

  // read data stands only with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

endmodule

// ===== tb/red_rssi_energy_detect_monitor.sv
// checker: bus and interrupt relations at the detector ports
module red_rssi_energy_detect_monitor (
  input logic             pclk,
  input logic             presetn,
  input logic             psel,
  input logic             penable,
  input logic             pwrite,
  input logic [11:0]      paddr,
  input logic [31:0]      pwdata,
  input logic             pready,
  input logic [31:0]      prdata,
  input logic             pslverr,
  input red_pkg::red_rx_t rx_in,
  input logic             measure_done_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] idx;
  logic       wr_ok;
  logic       mask_ff;
  assign idx   = paddr[11:2];
  assign wr_ok = pready && pwrite && psel && penable;
  // mask mirror, irq checks need the gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mask_ff <= 1'b0;
    else if (wr_ok && idx == 10'h9)
      mask_ff <= pwdata[0];
  end
  a_ready_wait: assert property (
    psel && penable && !pready |=> pready) else $error("no pready");
  a_ready_once: assert property (
    pready |=> !pready) else $error("pready too long");
  a_ready_cause: assert property (
    pready |-> $past(psel && penable)) else $error("stray pready");
  a_err_unmapped: assert property (
    pready && !(idx inside {[10'h6:10'h9]}) |-> pslverr)
    else $error("unmapped not refused");
  a_err_mapped: assert property (
    pready && idx inside {[10'h6:10'h9]} |-> !pslverr && prdata[31:8] == 0)
    else $error("mapped access refused");
  a_energy_range: assert property (
    pready && !pwrite && idx == 10'h7
    |-> prdata[7:0] <= 8'h53 || prdata[7:0] == 8'hff)
    else $error("energy out of range");
  a_strength_range: assert property (
    pready && !pwrite && idx == 10'h6 |-> prdata[4:0] <= 5'h1c)
    else $error("strength out of range");
  a_manual_idle: assert property (
    wr_ok && idx == 10'h7 && !rx_in.rx_active && mask_ff
    |-> ##[1:2] measure_done_irq) else $error("no done irq");
  a_mask_off: assert property (
    wr_ok && idx == 10'h9 && !pwdata[0] |-> ##[1:2] !measure_done_irq)
    else $error("masked irq high");
  cover property (pready && pslverr);
  cover property ($rose(measure_done_irq));
  cover property (rx_in.header_det && rx_in.rx_active);
endmodule

bind red_rssi_energy_detect red_rssi_energy_detect_monitor mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .rx_in(rx_in),
  .measure_done_irq(measure_done_irq));

// ===== tb/red_host_model.sv
// host model: apb master on the detector register bus
module red_host_model (
  input  logic        pclk,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0]  pstrb,
  input  logic        pready,
  input  logic [31:0] prdata,
  input  logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
  end
  task automatic xfer(input logic w, input logic [9:0] i,
      input logic [31:0] d, output logic [31:0] q, output logic e,
      output bit hung);
    hung = 1'b1;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        q = prdata;
        e = pslverr;
        hung = 1'b0;
        break;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ===== tb/tb_rssi_energy_detect.sv
// testbench: strength readout and energy detection
module tb_rssi_energy_detect;
  timeunit 1ns;
  timeprecision 1ps;
  logic             pclk, presetn, psel, penable, pwrite, pready, e;
  logic             pslverr, irq;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, q;
  logic [3:0]       pstrb;
  red_pkg::red_rx_t rx;
  int unsigned      seed = 32'h837a62bf;
  int               miscompares = 0;
  int               checks_done = 0;
  int               p;
  int               n;
  red_rssi_energy_detect dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rx_in(rx), .measure_done_irq(irq));
  red_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // averaged strength in 3dB steps shown in 1dB, clipped at top
  function automatic logic [31:0] exp_ed(input int v);
    int s = 64 * v * 3 / 64;
    return (s > 83) ? 32'd83 : 32'(s);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [9:0] i,
      input logic [31:0] d);
    bit h;
    host_u.xfer(w, i, d, q, e, h);
    if (h) begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // bounded wait for the done interrupt; expiry ends the run
  task automatic wait_irq(output int cnt);
    cnt = 0;
    while (cnt < 22500 && irq !== 1'b1) begin
      cyc(1);
      cnt++;
    end
    if (irq !== 1'b1) begin
      miscompares++;
      stop_test();
    end
  endtask
  initial begin
    presetn = 1'b0;
    rx = '0;
    rx.random_bits = 2'b11;
    cyc(4);
    presetn <= 1'b1;
    bus(0, 10'h6, 0);
    chk("strength", q, 32'h60);
    bus(1, 10'h6, rnd());
    bus(0, 10'h6, 0);
    chk("strength ro", q, 32'h60);
    bus(0, 10'h7, 0);
    chk("energy", q, 32'hff);
    bus(0, 10'ha, 0);
    chk("unmapped", {e, q[30:0]}, 32'h80000000);
    bus(1, 10'h9, 1);
    bus(1, 10'h7, rnd());
    cyc(2);
    chk("irq idle", {31'h0, irq}, 1);
    bus(0, 10'h7, 0);
    chk("energy idle", q, 32'hff);
    bus(1, 10'h8, 1);
    bus(0, 10'h8, 0);
    chk("status clr", q, 0);
    $display("test registers done");
    p = rnd() % 29;
    rx.power <= p[4:0];
    rx.rx_active <= 1'b1;
    cyc(260);
    bus(0, 10'h6, 0);
    chk("strength rx", q, 32'h60 | p);
    bus(1, 10'h7, rnd());
    wait_irq(n);
    chk("irq done", {31'h0, irq}, 1);
    // 64 samples span at least 63 periods; 180us at most
    chk("done time", 32'(n >= 15750 && n <= 22500), 1);
    bus(0, 10'h7, 0);
    chk("energy manual", q, exp_ed(p));
    bus(1, 10'h8, 1);
    $display("test manual done");
    rx.power <= 5'h1c;
    cyc(260);
    rx.header_det <= 1'b1;
    cyc(1);
    rx.header_det <= 1'b0;
    cyc(22500);
    chk("irq auto", {31'h0, irq}, 0);
    bus(0, 10'h7, 0);
    chk("energy auto", q, exp_ed(28));
    rx.power <= 5'h00;
    bus(1, 10'h7, rnd());
    cyc(2);
    chk("irq locked", {31'h0, irq}, 1);
    cyc(17000);
    bus(0, 10'h7, 0);
    chk("energy held", q, exp_ed(28));
    bus(1, 10'h9, 0);
    cyc(2);
    chk("irq masked", {31'h0, irq}, 0);
    $display("test auto done");
    // frame end: checksum flag latched, frame lock released
    bus(1, 10'h8, 1);
    bus(1, 10'h9, 1);
    p = rnd() % 29;
    rx.power <= p[4:0];
    rx.crc_ok <= 1'b1;
    rx.frame_end <= 1'b1;
    cyc(1);
    rx.frame_end <= 1'b0;
    cyc(260);
    bus(0, 10'h6, 0);
    chk("strength crc", q, 32'he0 | p);
    bus(1, 10'h7, rnd());
    wait_irq(n);
    chk("next done time", 32'(n >= 15750 && n <= 22500), 1);
    bus(0, 10'h7, 0);
    chk("energy next", q, exp_ed(p));
    $display("test frame end done");
    stop_test();
  end
endmodule
